// *** rtl/chgsp_pkg.sv ***
package chgsp_pkg;

  // ***********************************************************
  // Register map
  // ***********************************************************
  localparam logic [7:0] FC_OFFSET = 8'h03;
  localparam logic [7:0] TP_OFFSET = 8'h04;
  localparam logic [7:0] BV_OFFSET = 8'h05;
  localparam logic [7:0] SO_OFFSET = 8'h06;
  localparam logic [7:0] FC_RESET = 8'h14;
  localparam logic [7:0] TP_RESET = 8'h0e;
  localparam logic [7:0] BV_RESET = 8'h78;
  localparam logic [7:0] SO_RESET = 8'haa;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int RANGE_BIT = 7;
  localparam int CODE_MSB = 6;
  localparam int CODE_LSB = 2;
  localparam int CHG_DIS_BIT = 1;
  localparam int HIZ_BIT = 0;
  localparam int TERM_EN_BIT = 1;
  localparam int VB_MSB = 7;
  localparam int VB_LSB = 1;
  localparam int SYS_EN_BIT = 7;
  localparam logic [4:0] CODE_ALL_ONES = 5'h1f;

  // ***********************************************************
  // Setpoint arithmetic (mA, 500 uA units, mV)
  // ***********************************************************
  localparam int CHG_MA_W = 9;
  localparam int TERM_W = 7;
  localparam int VBAT_W = 13;
  localparam logic [12:0] CHG_LO_BASE = 13'h0005;
  localparam logic [12:0] CHG_LO_STEP = 13'h0001;
  localparam logic [12:0] CHG_LO_MAX = 13'h0023;
  localparam logic [12:0] CHG_HI_BASE = 13'h0028;
  localparam logic [12:0] CHG_HI_STEP = 13'h000a;
  localparam logic [12:0] CHG_HI_MAX = 13'h012c;
  localparam logic [12:0] TERM_LO_BASE = 13'h0001;
  localparam logic [12:0] TERM_LO_STEP = 13'h0001;
  localparam logic [12:0] TERM_LO_MAX = 13'h000a;
  localparam logic [12:0] TERM_HI_BASE = 13'h000c;
  localparam logic [12:0] TERM_HI_STEP = 13'h0002;
  localparam logic [12:0] TERM_HI_MAX = 13'h004a;
  localparam logic [12:0] VBAT_BASE = 13'h0e10;
  localparam logic [12:0] VBAT_STEP = 13'h000a;
  localparam logic [12:0] VBAT_MAX = 13'h122a;

  // ***********************************************************
  // Serial slave
  // ***********************************************************
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_ACK_A = 7'b0000100,
    ST_WRITE = 7'b0001000,
    ST_ACK_W = 7'b0010000,
    ST_READ  = 7'b0100000,
    ST_ACK_R = 7'b1000000
  } chgsp_state_t;

endpackage : chgsp_pkg

// *** rtl/chgsp_setpt_if.sv ***
`timescale 1ns/1ps
interface chgsp_setpt_if;
  import chgsp_pkg::*;
  // Register contents toward the decoder
  logic [7:0] fc_reg;
  logic [7:0] tp_reg;
  logic [7:0] bv_reg;
  logic [7:0] so_reg;
  logic chg_written;
  logic term_written;
  // Decoded setpoints back to the bank
  logic [CHG_MA_W-1:0] chg_ma;
  logic chg_ext;
  logic [TERM_W-1:0] term_half_ma;
  logic te_eff;
  logic [VBAT_W-1:0] vbat_mv;
  logic chg_en;
  logic hiz;
  logic sys_en;

  modport bank(output fc_reg, tp_reg, bv_reg, so_reg, chg_written,
    term_written, input chg_ma, chg_ext, term_half_ma, te_eff, vbat_mv,
    chg_en, hiz, sys_en);
  modport calc(input fc_reg, tp_reg, bv_reg, so_reg, chg_written,
    term_written, output chg_ma, chg_ext, term_half_ma, te_eff, vbat_mv,
    chg_en, hiz, sys_en);
endinterface : chgsp_setpt_if

// *** rtl/chgsp_setpoint.sv ***
`timescale 1ns/1ps
module chgsp_setpoint (
  // Clock and reset
  input wire logic core_clk,
  input wire logic core_clk_en,
  input wire logic sys_rst,
  // Register side
  chgsp_setpt_if.calc sp,
  // Pin-programmed defaults and loop status
  input wire logic [chgsp_pkg::CHG_MA_W-1:0] chg_res_ma,
  input wire logic [chgsp_pkg::CHG_MA_W-1:0] chg_otp_ma,
  input wire logic charge_current_set_pin_gnd,
  input wire logic [chgsp_pkg::TERM_W-1:0] term_res_half_ma,
  input wire logic [chgsp_pkg::TERM_W-1:0] term_otp_half_ma,
  input wire logic term_set_pin_gnd,
  input wire logic input_voltage_power_loop,
  input wire logic cool_temp_loop
);
  import chgsp_pkg::*;

  typedef struct packed {
    logic [CHG_MA_W-1:0] chg_ma;
    logic chg_ext;
    logic [TERM_W-1:0] term;
    logic te_eff;
    logic [VBAT_W-1:0] vbat;
    logic chg_en;
    logic hiz;
    logic sys_en;
  } chgsp_calc_t;

  localparam chgsp_calc_t CALC_RST = '0;

  chgsp_calc_t calc_reg;
  chgsp_calc_t calc_next;
  logic [4:0] chg_code;
  logic [4:0] term_code;
  logic [12:0] chg_val;
  logic [12:0] term_val;

  // Base plus code times step, saturated at the top
  function automatic logic [12:0] lin_clamp(input logic [12:0] base,
    input logic [12:0] step, input logic [6:0] code,
    input logic [12:0] top);
    logic [12:0] v;
    v = base + step * 13'(code);
    return (v > top) ? top : v;
  endfunction : lin_clamp

  // ***********************************************************
  // Setpoint decode
  // ***********************************************************
  always_comb begin
    calc_next = calc_reg;
    chg_code = sp.fc_reg[CODE_MSB:CODE_LSB];
    term_code = sp.tp_reg[CODE_MSB:CODE_LSB];
    chg_val = sp.fc_reg[RANGE_BIT] ?
      lin_clamp(CHG_HI_BASE, CHG_HI_STEP, {2'b00, chg_code},
        CHG_HI_MAX) :
      lin_clamp(CHG_LO_BASE, CHG_LO_STEP, {2'b00, chg_code},
        CHG_LO_MAX);
    term_val = sp.tp_reg[RANGE_BIT] ?
      lin_clamp(TERM_HI_BASE, TERM_HI_STEP, {2'b00, term_code},
        TERM_HI_MAX) :
      lin_clamp(TERM_LO_BASE, TERM_LO_STEP, {2'b00, term_code},
        TERM_LO_MAX);
    // External value until written, or on the all-ones code
    calc_next.chg_ext = !sp.chg_written ||
      (chg_code == CODE_ALL_ONES);
    if (calc_next.chg_ext) begin
      calc_next.chg_ma = charge_current_set_pin_gnd ? chg_otp_ma :
        chg_res_ma;
    end else begin
      calc_next.chg_ma = chg_val[CHG_MA_W-1:0];
    end
    if (!sp.term_written) begin
      calc_next.term = term_set_pin_gnd ? term_otp_half_ma :
        term_res_half_ma;
    end else begin
      calc_next.term = term_val[TERM_W-1:0];
    end
    calc_next.te_eff = sp.tp_reg[TERM_EN_BIT] &&
      !input_voltage_power_loop && !cool_temp_loop;
    calc_next.vbat = lin_clamp(VBAT_BASE, VBAT_STEP,
      sp.bv_reg[VB_MSB:VB_LSB], VBAT_MAX);
    calc_next.chg_en = !sp.fc_reg[CHG_DIS_BIT];
    calc_next.hiz = sp.fc_reg[HIZ_BIT];
    calc_next.sys_en = sp.so_reg[SYS_EN_BIT];
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      calc_reg <= CALC_RST;
    end else if (core_clk_en) begin
      calc_reg <= calc_next;
    end
  end

  // Results toward the bank
  assign sp.chg_ma = calc_reg.chg_ma;
  assign sp.chg_ext = calc_reg.chg_ext;
  assign sp.term_half_ma = calc_reg.term;
  assign sp.te_eff = calc_reg.te_eff;
  assign sp.vbat_mv = calc_reg.vbat;
  assign sp.chg_en = calc_reg.chg_en;
  assign sp.hiz = calc_reg.hiz;
  assign sp.sys_en = calc_reg.sys_en;

endmodule : chgsp_setpoint

// *** rtl/chgsp_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Charge control register resets to 0x14; all eight bits read/write.
// - Low range: charge current is 5 mA plus code times 1 mA.
// - High range: charge current is 40 mA plus code times 10 mA.
// - Code bits 6 down to 2 weigh 16, 8, 4, 2, 1 steps.
// - Charge setting saturates at 35 mA low range, 300 mA high.
// - All-ones charge code selects the pin-programmed charge current.
// - Charger-disable bit 1 at zero charges; at one stops; resets zero.
// - Bit 0 set selects high impedance mode; resets to zero.
// - Charge default from set-pin resistor, or OTP when pin grounded.
// - Termination register resets to 0x0e, read/write, termination on.
// - One termination code sets both termination and pre-charge current.
// - Termination: 500 uA plus code times 500 uA, or 6 mA plus code mA.
// - Termination code bits 6 down to 2 weigh 16, 8, 4, 2, 1 steps.
// - Low-range termination setting saturates at 5 mA.
// - Low-current termination only while enable bit 1 is one; resets one.
// - Termination suppressed while input-voltage or cool loop is active.
// - Termination default from pin resistor, or OTP when pin grounded.
// - Battery voltage register resets to 0x78, all bits read/write.
// - Battery voltage is 3.6 V plus bits 7..1 code times 10 mV.
// - Battery voltage setting saturates at 4.65 V.
// - System output register resets to 0xaa, all bits read/write.
// - System output bit 7 enables output; cleared pulls output low.
module chgsp_regs #(
  parameter logic [6:0] DEV_ADDR = chgsp_pkg::DEV_ADDR_DEFAULT // Arbitrary
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic core_clk_en,
  input wire logic sys_rst,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Pin-programmed defaults and loop status
  input wire logic [chgsp_pkg::CHG_MA_W-1:0] chg_res_ma,
  input wire logic [chgsp_pkg::CHG_MA_W-1:0] chg_otp_ma,
  input wire logic charge_current_set_pin_gnd,
  input wire logic [chgsp_pkg::TERM_W-1:0] term_res_half_ma,
  input wire logic [chgsp_pkg::TERM_W-1:0] term_otp_half_ma,
  input wire logic term_set_pin_gnd,
  input wire logic input_voltage_power_loop,
  input wire logic cool_temp_loop,
  // Setpoint outputs
  output logic [chgsp_pkg::CHG_MA_W-1:0] charge_current_ma,
  output logic charge_current_ext,
  output logic [chgsp_pkg::TERM_W-1:0] term_current_half_ma,
  output logic [chgsp_pkg::TERM_W-1:0] precharge_current_half_ma,
  output logic termination_enable,
  output logic [chgsp_pkg::VBAT_W-1:0] battery_reg_mv,
  output logic charge_enable,
  output logic high_impedance_sel,
  output logic system_output_enable,
  output logic system_output_pull_low
);
  import chgsp_pkg::*;

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    chgsp_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic ptr_phase;
    logic nack;
    logic sda_hold;
    logic [7:0] fc;
    logic [7:0] tp;
    logic [7:0] bv;
    logic [7:0] so;
    logic chg_wr;
    logic term_wr;
  } chgsp_bank_t;

  localparam chgsp_bank_t BANK_RST = '{
    scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
    st: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, ptr: 8'h00,
    ptr_phase: 1'b1, nack: 1'b0, sda_hold: 1'b0,
    fc: FC_RESET, tp: TP_RESET, bv: BV_RESET, so: SO_RESET,
    chg_wr: 1'b0, term_wr: 1'b0};

  chgsp_bank_t r;
  chgsp_bank_t n;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd_byte;

  chgsp_setpt_if sp ();

  // Register read mux; unmapped pointers read as zero
  function automatic logic [7:0] reg_read(input logic [7:0] ptr,
    input chgsp_bank_t s);
    logic [7:0] v;
    v = UNMAPPED_READ;
    if (ptr == FC_OFFSET) begin
      v = s.fc;
    end else if (ptr == TP_OFFSET) begin
      v = s.tp;
    end else if (ptr == BV_OFFSET) begin
      v = s.bv;
    end else if (ptr == SO_OFFSET) begin
      v = s.so;
    end
    return v;
  endfunction : reg_read

  // ***********************************************************
  // Bus events from synchronised pins
  // ***********************************************************
  assign scl_s = r.scl_sync[1];
  assign sda_s = r.sda_sync[1];
  assign scl_rise = scl_s && !r.scl_prev;
  assign scl_fall = !scl_s && r.scl_prev;
  assign start_seen = scl_s && r.scl_prev && r.sda_prev && !sda_s;
  assign stop_seen = scl_s && r.scl_prev && !r.sda_prev && sda_s;
  assign rd_byte = reg_read(r.ptr, r);

  // ***********************************************************
  // Slave sequencer and register file
  // ***********************************************************
  always_comb begin
    n = r;
    n.scl_sync = {r.scl_sync[0], scl_in};
    n.sda_sync = {r.sda_sync[0], sda_in};
    n.scl_prev = scl_s;
    n.sda_prev = sda_s;
    if (stop_seen) begin
      n.st = ST_IDLE;
      n.sda_hold = 1'b0;
    end else if (start_seen) begin
      n.st = ST_ADDR;
      n.bitcnt = 4'h0;
      n.ptr_phase = 1'b1;
      n.sda_hold = 1'b0;
    end else begin
      unique case (r.st)
        ST_IDLE: begin
          n.sda_hold = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            n.shreg = {r.shreg[6:0], sda_s};
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == BYTE_BITS) begin
            if (r.shreg[7:1] == DEV_ADDR) begin
              n.sda_hold = 1'b1;
              n.st = ST_ACK_A;
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            n.bitcnt = 4'h0;
            if (r.shreg[0]) begin
              n.shreg = rd_byte;
              n.ptr = r.ptr + 8'h01;
              n.sda_hold = !rd_byte[7];
              n.st = ST_READ;
            end else begin
              n.sda_hold = 1'b0;
              n.st = ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (scl_rise) begin
            n.shreg = {r.shreg[6:0], sda_s};
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == BYTE_BITS) begin
            n.sda_hold = 1'b1;
            n.st = ST_ACK_W;
            if (r.ptr_phase) begin
              n.ptr = r.shreg;
              n.ptr_phase = 1'b0;
            end else begin
              n.ptr = r.ptr + 8'h01;
              if (r.ptr == FC_OFFSET) begin
                n.fc = r.shreg;
                n.chg_wr = 1'b1;
              end else if (r.ptr == TP_OFFSET) begin
                n.tp = r.shreg;
                n.term_wr = 1'b1;
              end else if (r.ptr == BV_OFFSET) begin
                n.bv = r.shreg;
              end else if (r.ptr == SO_OFFSET) begin
                n.so = r.shreg;
              end
            end
          end
        end
        ST_ACK_W: begin
          if (scl_fall) begin
            n.sda_hold = 1'b0;
            n.bitcnt = 4'h0;
            n.st = ST_WRITE;
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (r.bitcnt == BYTE_BITS) begin
              n.sda_hold = 1'b0;
              n.st = ST_ACK_R;
            end else begin
              n.shreg = {r.shreg[6:0], 1'b0};
              n.sda_hold = !r.shreg[6];
            end
          end
        end
        ST_ACK_R: begin
          if (scl_rise) begin
            n.nack = sda_s;
          end else if (scl_fall) begin
            if (r.nack) begin
              n.st = ST_IDLE;
            end else begin
              n.shreg = rd_byte;
              n.ptr = r.ptr + 8'h01;
              n.bitcnt = 4'h0;
              n.sda_hold = !rd_byte[7];
              n.st = ST_READ;
            end
          end
        end
        default: begin
          n.st = ST_IDLE;
          n.sda_hold = 1'b0;
        end
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= BANK_RST;
    end else if (core_clk_en) begin
      r <= n;
    end
  end

  // ***********************************************************
  // Setpoint decoder and outputs
  // ***********************************************************
  assign sp.fc_reg = r.fc;
  assign sp.tp_reg = r.tp;
  assign sp.bv_reg = r.bv;
  assign sp.so_reg = r.so;
  assign sp.chg_written = r.chg_wr;
  assign sp.term_written = r.term_wr;

  chgsp_setpoint u_setpoint (
    .core_clk(core_clk),
    .core_clk_en(core_clk_en),
    .sys_rst(sys_rst),
    .sp(sp.calc),
    .chg_res_ma(chg_res_ma),
    .chg_otp_ma(chg_otp_ma),
    .charge_current_set_pin_gnd(charge_current_set_pin_gnd),
    .term_res_half_ma(term_res_half_ma),
    .term_otp_half_ma(term_otp_half_ma),
    .term_set_pin_gnd(term_set_pin_gnd),
    .input_voltage_power_loop(input_voltage_power_loop),
    .cool_temp_loop(cool_temp_loop)
  );

  // Open-drain data pin: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = !r.sda_hold;
  assign charge_current_ma = sp.chg_ma;
  assign charge_current_ext = sp.chg_ext;
  assign term_current_half_ma = sp.term_half_ma;
  assign precharge_current_half_ma = sp.term_half_ma;
  assign termination_enable = sp.te_eff;
  assign battery_reg_mv = sp.vbat_mv;
  assign charge_enable = sp.chg_en;
  assign high_impedance_sel = sp.hiz;
  assign system_output_enable = sp.sys_en;
  assign system_output_pull_low = !sp.sys_en;

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  chk_fc_reset_val: assert property (
    disable iff (1'b0) sys_rst |=> r.fc == 8'h14)
    else $error("charge register reset value wrong");
  chk_tp_reset_val: assert property (
    disable iff (1'b0) sys_rst |=> r.tp == 8'h0e && r.tp[1])
    else $error("termination register reset value wrong");
  chk_bv_reset_val: assert property (
    disable iff (1'b0) sys_rst |=> r.bv == 8'h78)
    else $error("battery register reset value wrong");
  chk_so_reset_val: assert property (
    disable iff (1'b0) sys_rst |=> r.so == 8'haa)
    else $error("system output register reset value wrong");
  chk_chg_low_range: assert property (
    core_clk_en && r.chg_wr && !r.fc[7] && r.fc[6:2] != 5'h1f
    |=> charge_current_ma == 9'(5 + $past(r.fc[6:2])))
    else $error("low range charge current wrong");
  chk_chg_high_range: assert property (
    core_clk_en && r.chg_wr && r.fc[7] && r.fc[6:2] < 5'h1b
    |=> charge_current_ma == 9'(40 + 10 * $past(r.fc[6:2])))
    else $error("high range charge current wrong");
  chk_chg_saturate: assert property (
    core_clk_en && r.chg_wr && r.fc[7] && r.fc[6:2] inside {[5'h1b:5'h1e]}
    |=> charge_current_ma == 9'h12c && !charge_current_ext)
    else $error("charge current not saturated at 300 mA");
  chk_chg_external: assert property (
    core_clk_en && r.fc[6:2] == 5'h1f && charge_current_set_pin_gnd
    |=> charge_current_ext && charge_current_ma == $past(chg_otp_ma))
    else $error("all-ones code did not select pin value");
  chk_chg_disable: assert property (
    !sys_rst && core_clk_en |=> charge_enable == !$past(r.fc[1]))
    else $error("charge enable does not follow disable bit");
  chk_hiz_follow: assert property (
    !sys_rst && core_clk_en |=> high_impedance_sel == $past(r.fc[0]))
    else $error("high impedance does not follow its bit");
  chk_term_clamp: assert property (
    core_clk_en && r.term_wr && !r.tp[7] && r.tp[6:2] > 5'h09
    |=> term_current_half_ma == 7'h0a)
    else $error("termination not saturated at 5 mA");
  chk_term_suppress: assert property (
    core_clk_en && (input_voltage_power_loop || cool_temp_loop)
    |=> !termination_enable)
    else $error("termination active under another loop");
  chk_vbat_clamp: assert property (
    core_clk_en && r.bv[7:1] > 7'h69 |=> battery_reg_mv == 13'h122a)
    else $error("battery voltage not saturated at 4.65 V");
  chk_sys_pull_low: assert property (
    !sys_rst && core_clk_en |=> system_output_pull_low == !$past(r.so[7]))
    else $error("system output pull-low does not follow its bit");

  cov_reg_write: cover property (
    r.st == ST_WRITE && n.st == ST_ACK_W && !r.ptr_phase && core_clk_en);
  cov_reg_read: cover property (r.st == ST_ACK_R && n.st == ST_READ);
  cov_read_nack: cover property (r.st == ST_ACK_R && n.st == ST_IDLE);
  cov_ext_current: cover property (charge_current_ext && r.chg_wr);

endmodule : chgsp_regs

// *** tb/chgsp_host_model.sv ***
`timescale 1ns/1ps
// ******************
// Serial host model
// ******************
module chgsp_host_model (
  // Clock and wire level
  input wire logic core_clk,
  input wire logic sda_line,
  // Host pins, high is released
  output logic scl = 1'b1,
  output logic sda = 1'b1
);
  // Set both pins, then hold six clocks
  task automatic pn(input logic c, input logic d);
    scl <= c;
    sda <= d;
    repeat (6) @(posedge core_clk);
  endtask : pn
  // Start or repeated start
  task automatic st();
    pn(scl, 1'b1);
    pn(1'b1, 1'b1);
    pn(1'b1, 1'b0);
    pn(1'b0, 1'b0);
  endtask : st
  // Stop, leaves the bus idle
  task automatic sp();
    pn(1'b0, 1'b0);
    pn(1'b1, 1'b0);
    pn(1'b1, 1'b1);
  endtask : sp
  // Eight bits then the acknowledge bit, data only moves with clock low
  task automatic by(input logic [7:0] d, output logic [7:0] q,
      output logic a);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      pn(1'b0, s[i]);
      pn(1'b1, s[i]);
      r[i] = sda_line;
      pn(1'b0, s[i]);
    end
    q = r[8:1];
    a = r[0];
  endtask : by
  // One register write or one byte read, ok when all acknowledged
  task automatic xf(input logic [6:0] ad, input logic rn,
      input logic [7:0] p, input logic [7:0] d, output logic [7:0] q,
      output logic ok);
    logic [7:0] x;
    logic a0, a1, a2, a3;
    st();
    by({ad, 1'b0}, x, a0);
    by(p, x, a1);
    if (rn) begin
      st();
      by({ad, 1'b1}, x, a2);
      by(8'hff, q, a3);
    end else begin
      by(d, x, a2);
    end
    sp();
    ok = !(a0 | a1 | a2);
  endtask : xf
endmodule : chgsp_host_model

// *** tb/charger_setpoint_registers_bench.sv ***
`timescale 1ns/1ps
module charger_setpoint_registers_bench;
  import chgsp_pkg::*;
  // ************************
  // Signals, inputs at rest
  // ************************
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic charge_current_set_pin_gnd = 1'b0, term_set_pin_gnd = 1'b0;
  logic input_voltage_power_loop = 1'b0, cool_temp_loop = 1'b0;
  logic [8:0] chg_res_ma = 9'h064, chg_otp_ma = 9'h032, charge_current_ma;
  logic [6:0] term_res_half_ma = 7'h08, term_otp_half_ma = 7'h04;
  logic [6:0] term_current_half_ma, precharge_current_half_ma;
  logic [12:0] battery_reg_mv;
  logic scl, sda, sda_out, sda_oe_n, ok, charge_current_ext, charge_enable;
  logic termination_enable, high_impedance_sel, system_output_enable;
  logic system_output_pull_low;
  logic [7:0] q;
  int error_cnt, compares, cyc;
  wire logic sda_line = sda & (sda_oe_n | sda_out);
  chgsp_regs u_dut (.core_clk, .core_clk_en(1'b1), .sys_rst, .scl_in(scl),
    .sda_in(sda_line), .sda_out, .sda_oe_n, .chg_res_ma, .chg_otp_ma,
    .charge_current_set_pin_gnd, .term_res_half_ma, .term_otp_half_ma,
    .term_set_pin_gnd, .input_voltage_power_loop, .cool_temp_loop,
    .charge_current_ma, .charge_current_ext, .term_current_half_ma,
    .precharge_current_half_ma, .termination_enable, .battery_reg_mv,
    .charge_enable, .high_impedance_sel, .system_output_enable,
    .system_output_pull_low);
  chgsp_host_model u_host (.core_clk, .sda_line, .scl, .sda);
  // Clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // Compare and count
  task automatic chk(string n, logic [12:0] e, logic [12:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Write, or read and compare
  task automatic ax(logic rn, logic [7:0] p, logic [7:0] d);
    u_host.xf(DEV_ADDR_DEFAULT, rn, p, d, q, ok);
    chk("ack", 13'h1, 13'(ok));
    if (rn) begin
      chk("rdata", 13'(d), 13'(q));
    end
  endtask : ax
  // Pin wait
  task automatic hold();
    repeat (4) @(posedge core_clk);
  endtask : hold
  task automatic t_reset();
    ax(1'b1, FC_OFFSET, FC_RESET);
    ax(1'b1, TP_OFFSET, TP_RESET);
    ax(1'b1, BV_OFFSET, BV_RESET);
    ax(1'b1, SO_OFFSET, SO_RESET);
    chk("chg", 13'h0c9,
      13'({charge_current_ma, charge_current_ext}));
    chk("flags", 13'h5, 13'({charge_enable, high_impedance_sel,
      termination_enable}));
    chk("term", 13'h08, 13'(term_current_half_ma));
    term_set_pin_gnd <= 1'b1;
    hold();
    chk("term", 13'h04, 13'(term_current_half_ma));
    chk("vbat", 13'h1068, battery_reg_mv);
    chk("sys", 13'h1, 13'(system_output_enable));
  endtask : t_reset
  task automatic t_charge();
    logic [7:0] w[5] = '{8'h00, 8'h78, 8'h80, 8'hee, 8'hd9};
    logic [8:0] e[5] = '{9'h005, 9'h023, 9'h028, 9'h12c, 9'h104};
    foreach (w[i]) begin
      ax(1'b0, FC_OFFSET, w[i]);
      chk("chg", 13'(e[i]), 13'(charge_current_ma));
      chk("fc_bits", 13'({~w[i][1], w[i][0]}),
        13'({charge_enable, high_impedance_sel}));
    end
    ax(1'b1, FC_OFFSET, 8'hd9);
    ax(1'b0, FC_OFFSET, 8'h7c);
    chk("ext", 13'h0c9,
      13'({charge_current_ma, charge_current_ext}));
    charge_current_set_pin_gnd <= 1'b1;
    hold();
    chk("otp", 13'h032, 13'(charge_current_ma));
  endtask : t_charge
  task automatic t_term();
    logic [7:0] w[4] = '{8'h02, 8'h28, 8'hfe, 8'h8f};
    logic [6:0] e[4] = '{7'h01, 7'h0a, 7'h4a, 7'h12};
    foreach (w[i]) begin
      ax(1'b0, TP_OFFSET, w[i]);
      chk("term", 13'(e[i]), 13'(term_current_half_ma));
      chk("pre", 13'(e[i]), 13'(precharge_current_half_ma));
      chk("te", 13'(w[i][1]), 13'(termination_enable));
    end
    ax(1'b1, TP_OFFSET, 8'h8f);
    input_voltage_power_loop <= 1'b1;
    hold();
    chk("te", 13'h0, 13'(termination_enable));
    input_voltage_power_loop <= 1'b0;
    cool_temp_loop <= 1'b1;
    hold();
    chk("te", 13'h0, 13'(termination_enable));
  endtask : t_term
  task automatic t_vbat();
    logic [7:0] w[4] = '{8'h00, 8'hd0, 8'hff, 8'h51};
    logic [12:0] e[4] = '{13'h0e10, 13'h1220, 13'h122a, 13'h0fa0};
    foreach (w[i]) begin
      ax(1'b0, BV_OFFSET, w[i]);
      chk("vbat", e[i], battery_reg_mv);
    end
    ax(1'b1, BV_OFFSET, 8'h51);
  endtask : t_vbat
  task automatic t_misc();
    ax(1'b0, SO_OFFSET, 8'h2a);
    chk("sys", 13'h1,
      13'({system_output_enable, system_output_pull_low}));
    ax(1'b1, SO_OFFSET, 8'h2a);
    ax(1'b0, 8'h09, 8'h5a);
    ax(1'b1, 8'h09, UNMAPPED_READ);
    u_host.xf(7'h15, 1'b0, FC_OFFSET, 8'h00, q, ok);
    chk("nack", 13'h0, 13'(ok));
    ax(1'b1, FC_OFFSET, 8'h7c);
  endtask : t_misc
  // Verdict
  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    hold();
    t_reset();
    t_charge();
    t_term();
    t_vbat();
    t_misc();
    end_of_test();
  end
endmodule : charger_setpoint_registers_bench
